// ==== core/cbls_core.sv ====
/*
 Execution unit for compares, register and I/O bit skips, flag branches,
 moves, immediate loads and data memory loads and stores, with an AXI4-Lite
 slave for control, status flags and program counter.
 Assumes the fetch side presents the instruction word, the following word,
 a flag saying whether the following instruction is two words long, and the
 I/O byte that a skip-on-I/O-bit instruction names. Data memory returns read
 data in the cycle in which the read strobe is high.
*/
// Local design decisions: the register addresses and the AXI4-Lite slave port.
// Notes on behaviour
// - Compares subtract, set flags, one cycle
// - Register bit skip advances two or three
// - I/O bit skip on match, flags kept
// - Flag branch by index to pc+k+1
// - Zero, carry, negative branches on flag
// - Same-higher is carry clear, lower carry set
// - Signed greater-equal when N xor V zero
// - Signed less-than when N xor V one
// - Half-carry branches on H flag
// - Transfer branches on T flag
// - Overflow branches on V flag
// - Interrupt-enabled branch when I set
// - Post-increment load reads then bumps pointer
// - Pre-decrement load decrements then reads
// - Displacement load via Y or Z, pointer kept
// - Direct load from absolute address, two cycles
// - Post-increment and plain stores, two cycles
// - Pre-decrement store decrements then writes
`timescale 1ns/10ps
`include "cbls_defs.svh"
module cbls_core
    import cbls_pkg::*;
#(
    parameter int PC_W = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_ext,
    input wire logic next_two_word,
    input wire logic [7:0] io_data,
    output logic instr_ready_reg,
    output logic [PC_W-1:0] pc_reg,
    output logic [7:0] flags_reg,
    output logic [15:0] dmem_addr_reg,
    output logic [7:0] dmem_wdata_reg,
    output logic dmem_we_reg,
    output logic dmem_re_reg,
    input wire logic [7:0] dmem_rdata,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    generate
        if (PC_W < 8 || PC_W > 16) begin : g_bad_pc
            $error("PC_W must lie between 8 and 16");
        end
    endgenerate

    logic rst_s1_reg;
    logic rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // Register bus decode, shared by reads and writes
    function automatic logic [2:0] reg_sel(input logic [3:0] addr);
        case (addr)
            `CBLS_OFS_CTRL: reg_sel = 3'h1;
            `CBLS_OFS_FLAGS: reg_sel = 3'h2;
            `CBLS_OFS_PC: reg_sel = 3'h3;
            `CBLS_OFS_STATE: reg_sel = 3'h4;
            default: reg_sel = 3'h0;
        endcase
    endfunction

    // Subtract with flags: returns {H,S,V,N,Z,C}
    function automatic logic [5:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin, input logic zkeep);
        logic [7:0] r;
        logic [7:0] bw;
        r = a - b - {7'h00, cin};
        bw = (~a & b) | (b & r) | (r & ~a);
        sub_flags = {bw[3], r[7] ^ ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7])),
                     (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]), r[7],
                     (r == 8'h00) & zkeep, bw[7]};
    endfunction

    cbls_state_t state_reg;
    cbls_state_t state_next;
    logic [1:0] stall_reg;
    logic [1:0] stall_next;
    logic [4:0] load_dst_reg;
    logic run_reg;
    cbls_byte_t rf [0:31];

    // Field extraction
    wire [4:0] f_d = instr_word[8:4];
    wire [4:0] f_r = {instr_word[9], instr_word[3:0]};
    wire [4:0] f_dh = {1'b1, instr_word[7:4]};
    wire [7:0] f_k = {instr_word[11:8], instr_word[3:0]};
    wire [2:0] f_b = instr_word[2:0];
    wire [6:0] f_off = instr_word[9:3];
    wire [5:0] f_q = {instr_word[13], instr_word[11:10], instr_word[2:0]};
    wire [3:0] f_m = instr_word[3:0];

    wire is_cmp = instr_word[15:10] == `CBLS_OP_CMP;
    wire is_cmpc = instr_word[15:10] == `CBLS_OP_CMPC;
    wire is_cmpi = instr_word[15:12] == `CBLS_OP_CMPI;
    wire is_move = instr_word[15:10] == `CBLS_OP_MOVE;
    wire is_ldimm = instr_word[15:12] == `CBLS_OP_LDIMM;
    wire is_skreg = instr_word[15:11] == `CBLS_OP_SKREG && instr_word[10] && !instr_word[3];
    wire is_skio = instr_word[15:10] == `CBLS_OP_SKIO && instr_word[8];
    wire is_br = instr_word[15:11] == `CBLS_OP_BRFLAG;
    wire is_disp = instr_word[15:14] == `CBLS_OP_DISP && !instr_word[12];
    wire ldst_mode_ok = f_m == 4'h0 || f_m == 4'h1 || f_m == 4'h2 || f_m == 4'h9 ||
                        f_m == 4'ha || f_m == 4'hc || f_m == 4'hd || f_m == 4'he;
    wire is_ldst = instr_word[15:10] == `CBLS_OP_LDST && ldst_mode_ok;
    wire is_mem = is_ldst || is_disp;
    wire is_store = instr_word[9];
    wire is_direct = is_ldst && f_m == 4'h0;
    wire post_inc = is_ldst && f_m[1:0] == 2'b01;
    wire pre_dec = is_ldst && f_m[1:0] == 2'b10;
    wire is_cmp_any = is_cmp || is_cmpc || is_cmpi;

    // Displacement form has only Y and Z; X exists only in the plain modes
    wire [4:0] ptr_idx = is_disp ? (instr_word[3] ? `CBLS_PTR_Y : `CBLS_PTR_Z) :
                         f_m[3:2] == 2'b11 ? `CBLS_PTR_X :
                         f_m[3] ? `CBLS_PTR_Y : `CBLS_PTR_Z;
    wire [4:0] ptr_hi_idx = ptr_idx | 5'h01;
    wire [15:0] ptr_val = {rf[ptr_hi_idx], rf[ptr_idx]};
    wire [15:0] ptr_dec = ptr_val - 16'h0001;
    wire [15:0] ptr_inc = ptr_val + 16'h0001;
    wire [15:0] mem_addr = is_direct ? instr_ext :
                           is_disp ? ptr_val + {10'h000, f_q} :
                           pre_dec ? ptr_dec : ptr_val;
    wire [15:0] ptr_new = pre_dec ? ptr_dec : ptr_inc;

    // Compare operands
    wire [7:0] cmp_a = is_cmpi ? rf[f_dh] : rf[f_d];
    wire [7:0] cmp_b = is_cmpi ? f_k : rf[f_r];
    wire cmp_cin = is_cmpc & flags_reg[`CBLS_F_C];
    wire cmp_zkeep = !is_cmpc | flags_reg[`CBLS_F_Z];
    wire [5:0] cmp_flags = sub_flags(cmp_a, cmp_b, cmp_cin, cmp_zkeep);

    // Named branches use a fixed index; S is read as N xor V, beyond a bus write's reach
    wire s_eff = flags_reg[`CBLS_F_N] ^ flags_reg[`CBLS_F_V];
    wire [7:0] br_flags = {flags_reg[7:5], s_eff, flags_reg[3:0]};
    wire br_taken = is_br && (br_flags[f_b] == !instr_word[10]);
    wire skip_bit = is_skreg ? rf[f_d][f_b] : io_data[f_b];
    wire skip_taken = (is_skreg || is_skio) && skip_bit == instr_word[9];

    wire [PC_W-1:0] pc_plus1 = pc_reg + PC_W'(1);
    wire [PC_W-1:0] br_target = pc_plus1 + {{(PC_W - 7){f_off[6]}}, f_off};
    wire [PC_W-1:0] skip_target = pc_reg + (next_two_word ? PC_W'(3) : PC_W'(2));
    wire [PC_W-1:0] mem_next = pc_reg + (is_direct ? PC_W'(2) : PC_W'(1));

    wire accept = ce && instr_ready_reg && instr_valid;
    wire in_load = ce && state_reg == CBLS_LOAD;

    wire [PC_W-1:0] pc_next = !accept ? pc_reg :
                              br_taken ? br_target :
                              skip_taken ? skip_target :
                              is_mem ? mem_next : pc_plus1;

    // Register bus channel state
    logic aw_got_reg;
    logic w_got_reg;
    logic [3:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire [2:0] wsel = reg_sel(awaddr_reg);
    wire [2:0] rsel = reg_sel(s_axi_araddr);
    wire wr_ctrl = do_write && wsel == 3'h1 && wstrb0_reg;
    wire wr_flags = do_write && wsel == 3'h2 && wstrb0_reg;
    wire aw_got_next = (aw_got_reg || aw_hs) && !do_write;
    wire w_got_next = (w_got_reg || w_hs) && !do_write;
    wire bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
    wire rvalid_next = ar_hs || (s_axi_rvalid && !s_axi_rready);
    wire run_next = wr_ctrl ? wdata_reg[`CBLS_CTRL_RUN_BIT] : run_reg;
    wire [31:0] rd_word = rsel == 3'h1 ? {31'h0, run_reg} :
                          rsel == 3'h2 ? {24'h0, flags_reg} :
                          rsel == 3'h3 ? {{(32 - PC_W){1'b0}}, pc_reg} :
                          rsel == 3'h4 ? {27'h0, stall_reg, state_reg} : 32'h0;

    // Compare wins over a bus write to the flags in the same cycle
    wire [7:0] flags_next = (accept && is_cmp_any) ?
                            {flags_reg[7:6], cmp_flags} :
                            wr_flags ? wdata_reg[7:0] : flags_reg;

    always_comb begin
        state_next = state_reg;
        stall_next = stall_reg;
        case (state_reg)
            CBLS_RUN: begin
                if (accept && is_mem && !is_store) begin
                    state_next = CBLS_LOAD;
                end else if (accept && is_mem) begin
                    state_next = CBLS_STALL;
                    stall_next = 2'd1;
                end else if (accept && br_taken) begin
                    state_next = CBLS_STALL;
                    stall_next = 2'd1;
                end else if (accept && skip_taken) begin
                    state_next = CBLS_STALL;
                    stall_next = next_two_word ? 2'd2 : 2'd1;
                end
            end
            CBLS_LOAD: state_next = CBLS_RUN;
            CBLS_STALL: begin
                stall_next = stall_reg - 2'd1;
                if (stall_reg == 2'd1) begin
                    state_next = CBLS_RUN;
                end
            end
            default: state_next = CBLS_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CBLS_RUN;
            stall_reg <= 2'd0;
            instr_ready_reg <= 1'b0;
            pc_reg <= '0;
            flags_reg <= `CBLS_FLAGS_RST;
            run_reg <= `CBLS_CTRL_RST;
        end else if (ce) begin
            state_reg <= state_next;
            stall_reg <= stall_next;
            instr_ready_reg <= state_next == CBLS_RUN && run_next;
            pc_reg <= pc_next;
            flags_reg <= flags_next;
            run_reg <= run_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmem_addr_reg <= 16'h0000;
            dmem_wdata_reg <= 8'h00;
            dmem_we_reg <= 1'b0;
            dmem_re_reg <= 1'b0;
            load_dst_reg <= 5'd0;
        end else if (ce) begin
            dmem_we_reg <= accept && is_mem && is_store;
            dmem_re_reg <= accept && is_mem && !is_store;
            if (accept && is_mem) begin
                dmem_addr_reg <= mem_addr;
                dmem_wdata_reg <= rf[f_d];
                load_dst_reg <= f_d;
            end
        end
    end

    // Data storage, no reset; a pointer that is also the load target is undefined
    always_ff @(posedge clk) begin
        if (accept && (is_move || is_ldimm)) begin
            rf[is_move ? f_d : f_dh] <= is_move ? rf[f_r] : f_k;
        end
        if (accept && (post_inc || pre_dec)) begin
            rf[ptr_idx] <= ptr_new[7:0];
            rf[ptr_hi_idx] <= ptr_new[15:8];
        end
        if (in_load) begin
            rf[load_dst_reg] <= dmem_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CBLS_RESP_OKAY;
        end else if (ce) begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            s_axi_awready <= !aw_got_next;
            s_axi_wready <= !w_got_next;
            s_axi_bvalid <= bvalid_next;
            if (aw_hs) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bresp <= wsel == 3'h0 ? `CBLS_RESP_SLVERR : `CBLS_RESP_OKAY;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CBLS_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid <= rvalid_next;
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rsel == 3'h0 ? `CBLS_RESP_SLVERR : `CBLS_RESP_OKAY;
            end
        end
    end

    // Checks hold only while the clock enable stays high
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    AST_CMP_ONE_CYCLE: assert property (
        accept && is_cmp_any |=> instr_ready_reg && pc_reg == $past(pc_plus1)
            && flags_reg[`CBLS_F_Z] == $past(cmp_a == 8'(cmp_b + {7'h00, cmp_cin}) && cmp_zkeep))
        else $error("compare did not finish in one cycle with correct zero flag");
    AST_SKIPREG_TARGET: assert property (
        accept && is_skreg && skip_taken && !next_two_word
            |=> !instr_ready_reg ##1 instr_ready_reg && pc_reg == $past(pc_reg, 2) + PC_W'(2))
        else $error("register bit skip target or timing wrong");
    AST_SKIPIO_FLAGS: assert property (
        accept && is_skio |=> $stable(flags_reg) && (pc_reg != $past(pc_plus1)) == $past(skip_taken))
        else $error("I/O bit skip changed flags or mis-skipped");
    AST_BRANCH_TARGET: assert property (
        accept && br_taken |=> pc_reg == $past(br_target) && !instr_ready_reg)
        else $error("taken branch target wrong");
    AST_SIGNED_GE: assert property (
        accept && is_br && f_b == 3'(`CBLS_F_S) && instr_word[10]
            && (flags_reg[`CBLS_F_N] ^ flags_reg[`CBLS_F_V]) |=> pc_reg == $past(pc_plus1))
        else $error("signed greater-equal taken with N xor V set");
    AST_SIGNED_LT: assert property (
        accept && is_br && f_b == 3'(`CBLS_F_S) && !instr_word[10]
            && (flags_reg[`CBLS_F_N] ^ flags_reg[`CBLS_F_V]) |=> pc_reg == $past(br_target))
        else $error("signed less-than not taken with N xor V set");
    AST_LOAD_POSTINC: assert property (
        accept && post_inc && !is_store |=> dmem_re_reg && dmem_addr_reg == $past(ptr_val)
            ##1 instr_ready_reg == $past(run_reg, 2))
        else $error("post-increment load address or timing wrong");
    AST_LOAD_PREDEC: assert property (
        accept && pre_dec |=> dmem_addr_reg == $past(ptr_val) - 16'h0001)
        else $error("pre-decrement address not decremented pointer");
    AST_LOAD_DIRECT: assert property (
        accept && is_direct && !is_store |=> dmem_addr_reg == $past(instr_ext)
            && pc_reg == $past(pc_reg) + PC_W'(2))
        else $error("direct load address or program counter wrong");
    AST_STORE_STROBE: assert property (
        accept && is_mem && is_store |=> dmem_we_reg && dmem_wdata_reg == $past(rf[f_d])
            ##1 !dmem_we_reg)
        else $error("store strobe or data wrong");
    AST_MOVE_FLAGS: assert property (
        accept && (is_move || is_ldimm) |=> $stable(flags_reg) && instr_ready_reg == $past(run_reg))
        else $error("move or immediate load touched flags or stalled");
    AST_SKIP_TWO_WORD: assert property (
        accept && skip_taken && next_two_word |=> pc_reg == $past(pc_reg) + PC_W'(3)
            ##0 !instr_ready_reg [*2])
        else $error("skip over two-word instruction wrong");

    COV_BRANCH: cover property (accept && br_taken);
    COV_SKIP3: cover property (accept && skip_taken && next_two_word);
    COV_LOAD: cover property (accept && is_mem && !is_store ##1 in_load);
    COV_AXI_WRITE: cover property (do_write && wsel == 3'h1);
endmodule

// ==== core/cbls_defs.svh ====
/*
 Constants of the compare, branch and transfer execution unit: register map,
 status flag positions, reset values and instruction field codes.
 Assumes inclusion by bare name from the core and the testbench.
*/
`ifndef CBLS_DEFS_SVH
`define CBLS_DEFS_SVH

// Register map, byte addresses on the 32-bit register bus
`define CBLS_OFS_CTRL 4'h0
`define CBLS_OFS_FLAGS 4'h4
`define CBLS_OFS_PC 4'h8
`define CBLS_OFS_STATE 4'hc
`define CBLS_CTRL_RUN_BIT 0
`define CBLS_CTRL_RST 1'b0
`define CBLS_FLAGS_RST 8'h00
`define CBLS_RESP_OKAY 2'b00
`define CBLS_RESP_SLVERR 2'b10

// Status flag positions
`define CBLS_F_C 0
`define CBLS_F_Z 1
`define CBLS_F_N 2
`define CBLS_F_V 3
`define CBLS_F_S 4
`define CBLS_F_H 5

// Instruction field codes
`define CBLS_OP_CMP 6'h05
`define CBLS_OP_CMPC 6'h01
`define CBLS_OP_MOVE 6'h0b
`define CBLS_OP_CMPI 4'h3
`define CBLS_OP_LDIMM 4'he
`define CBLS_OP_SKREG 5'h1f
`define CBLS_OP_SKIO 6'h26
`define CBLS_OP_BRFLAG 5'h1e
`define CBLS_OP_LDST 6'h24
`define CBLS_OP_DISP 2'h2
`define CBLS_PTR_X 5'd26
`define CBLS_PTR_Y 5'd28
`define CBLS_PTR_Z 5'd30

`endif

// ==== core/cbls_pkg.sv ====
/*
 Types of the compare, branch and transfer execution unit.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cbls_pkg;
    typedef enum logic [2:0] {
        CBLS_RUN = 3'b001,
        CBLS_LOAD = 3'b010,
        CBLS_STALL = 3'b100
    } cbls_state_t;
    typedef logic [7:0] cbls_byte_t;
endpackage

// ==== tb/cbls_dmem.sv ====
/*
 Data memory model at the far side of the execution unit.
 Assumes a registered one-cycle write pulse and an asynchronous read.
*/
`timescale 1ns/10ps
module cbls_dmem (
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:511];
    logic [7:0] churn_reg;
    // Outside a read the bus moves every cycle, so a late sample cannot pass by luck
    assign rdata = re ? mem[addr[8:0]] : churn_reg;
    initial begin
        churn_reg = 8'h00;
        for (int i = 0; i < 512; i++) begin
            mem[i] = i[7:0] ^ 8'h5c;
        end
    end
    always @(posedge clk) begin
        churn_reg <= churn_reg + 8'h35;
        if (we) begin
            mem[addr[8:0]] <= wdata;
        end
    end
endmodule

// ==== tb/testbench.sv ====
/*
 Self-checking bench: register bus and instruction drivers, then scenarios.
 Assumes the core, its package and header, and the data memory model.
*/
`timescale 1ns/10ps
`include "cbls_defs.svh"
module testbench;
    import cbls_pkg::*;
    logic clk, nrst, ce, instr_valid, next_two_word, instr_ready_reg, dmem_we_reg, dmem_re_reg;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tk;
    logic [15:0] instr_word, instr_ext, dmem_addr_reg;
    logic [9:0] pc_reg, exp_pc, stp;
    logic [7:0] io_data, flags_reg, dmem_wdata_reg, dmem_rdata, exp_flags, fv;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_fail, n_tests, s, v, c, b;
    logic [4:0] sd [8] = '{5'd26, 5'd27, 5'd28, 5'd29, 5'd30, 5'd31, 5'd16, 5'd18};
    logic [7:0] sv [8] = '{8'h00, 8'h01, 8'hf0, 8'h00, 8'h01, 8'h01, 8'ha5, 8'h3c};

    cbls_core u_cbls_core (.clk, .nrst, .ce, .instr_valid, .instr_word, .instr_ext,
        .next_two_word, .io_data, .instr_ready_reg, .pc_reg, .flags_reg, .dmem_addr_reg,
        .dmem_wdata_reg, .dmem_we_reg, .dmem_re_reg, .dmem_rdata, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    cbls_dmem u_cbls_dmem (.clk(clk), .addr(dmem_addr_reg), .wdata(dmem_wdata_reg),
        .we(dmem_we_reg), .re(dmem_re_reg), .rdata(dmem_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang(input int i);
        if (i >= 50) begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        hang(i);
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [3:0] a);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        hang(i);
        @(posedge clk);
    endtask

    task automatic exec(input logic [15:0] w, input logic [15:0] x, input logic nt,
                        input logic [7:0] io, input logic [31:0] ncyc, input logic [9:0] st);
        int i;
        int n;
        instr_word <= w;
        instr_ext <= x;
        next_two_word <= nt;
        io_data <= io;
        instr_valid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (instr_ready_reg) break;
        end
        hang(i);
        instr_valid <= 1'b0;
        // Cycles are counted from the accepting edge to the edge where ready is back
        for (n = 1; n < 50; n++) begin
            @(posedge clk);
            if (instr_ready_reg) break;
        end
        hang(n);
        exp_pc = exp_pc + st;
        chk(32'(n), ncyc);
        chk({22'h0, pc_reg}, {22'h0, exp_pc});
        chk({24'h0, flags_reg}, {24'h0, exp_flags});
    endtask

    task automatic mem_op(input logic [15:0] w, input logic [9:0] st, input logic [15:0] a,
                          input logic wr, input logic [7:0] d);
        exec(w, a, 1'b0, 8'h00, 32'd2, st);
        chk({16'h0, dmem_addr_reg}, {16'h0, a});
        if (wr) chk({24'h0, dmem_wdata_reg}, {24'h0, d});
    endtask

    initial begin
        {nrst, instr_valid, next_two_word, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {instr_word, instr_ext, io_data, s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        ce = 1'b1;
        n_fail = 0;
        n_tests = 0;
        exp_pc = 10'h000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        axi_rd(`CBLS_OFS_FLAGS);
        chk(rd, {24'h0, `CBLS_FLAGS_RST});
        axi_rd(4'h2);
        chk({30'h0, rs}, {30'h0, `CBLS_RESP_SLVERR});
        axi_wr(4'h2, 32'h1);
        chk({30'h0, rs}, {30'h0, `CBLS_RESP_SLVERR});
        axi_wr(`CBLS_OFS_CTRL, 32'h1);
        chk({30'h0, rs}, {30'h0, `CBLS_RESP_OKAY});
        axi_wr(`CBLS_OFS_FLAGS, 32'hc0);
        exp_flags = 8'hc0;
        for (s = 0; s < 8; s++) begin
            exec({4'he, sv[s][7:4], sd[s][3:0], sv[s][3:0]}, 16'h0, 1'b0, 8'h00, 1, 1);
        end
        // T and I survive compares; only the arithmetic flags move
        exp_flags = 8'hc2;
        exec({4'h3, 4'ha, 4'h0, 4'h5}, 16'h0, 1'b0, 8'h00, 1, 1);
        exp_flags = 8'hf8;
        exec({6'b000101, 1'b1, 5'd16, 4'h2}, 16'h0, 1'b0, 8'h00, 1, 1);
        exec({5'b11110, 1'b0, 7'h05, 3'd4}, 16'h0, 1'b0, 8'h00, 2, 6);
        exec({5'b11110, 1'b1, 7'h05, 3'd4}, 16'h0, 1'b0, 8'h00, 1, 1);
        axi_wr(`CBLS_OFS_FLAGS, 32'h01);
        exp_flags = 8'h0d;
        exec({6'b000001, 1'b1, 5'd18, 4'h0}, 16'h0, 1'b0, 8'h00, 1, 1);
        axi_rd(`CBLS_OFS_FLAGS);
        chk(rd, 32'h0d);
        for (s = 0; s < 8; s++) for (v = 0; v < 2; v++) for (c = 0; c < 2; c++) begin
            fv = v ? (8'h01 << s) : ~(8'h01 << s);
            axi_wr(`CBLS_OFS_FLAGS, {24'h0, fv});
            exp_flags = fv;
            tk = (s == `CBLS_F_S ? fv[`CBLS_F_N] ^ fv[`CBLS_F_V] : fv[s]) ^ c[0];
            stp = tk ? 10'h3fe : 10'h001;
            exec({5'b11110, c[0], 7'h7d, s[2:0]}, 16'h0, 1'b0, 8'h00, tk ? 2 : 1, stp);
        end
        for (b = 0; b < 8; b++) for (v = 0; v < 2; v++) begin
            tk = (sv[6][b] == v[0]);
            stp = tk ? (b[0] ? 10'd3 : 10'd2) : 10'd1;
            exec({6'b111111, v[0], 5'd16, 1'b0, b[2:0]}, 16'h0, b[0], 8'h00, {22'h0, stp}, stp);
            tk = (sv[7][b] == v[0]);
            stp = tk ? (b[0] ? 10'd2 : 10'd3) : 10'd1;
            exec({6'b100110, v[0], 1'b1, 5'h0d, b[2:0]}, 16'h0, !b[0], sv[7], {22'h0, stp}, stp);
        end
        mem_op({6'b100100, 1'b1, 5'd16, 4'hd}, 1, 16'h0100, 1'b1, 8'ha5);
        mem_op({6'b100100, 1'b1, 5'd18, 4'hd}, 1, 16'h0101, 1'b1, 8'h3c);
        mem_op({6'b100100, 1'b0, 5'd17, 4'he}, 1, 16'h0101, 1'b0, 8'h00);
        mem_op({6'b100100, 1'b1, 5'd17, 4'he}, 1, 16'h0100, 1'b1, 8'h3c);
        mem_op({6'b100100, 1'b0, 5'd19, 4'hd}, 1, 16'h0100, 1'b0, 8'h00);
        mem_op({6'b100100, 1'b1, 5'd19, 4'hc}, 1, 16'h0101, 1'b1, 8'h3c);
        mem_op({6'b100100, 1'b1, 5'd16, 4'hc}, 1, 16'h0101, 1'b1, 8'ha5);
        mem_op({6'b100100, 1'b0, 5'd20, 4'h0}, 2, 16'h0100, 1'b0, 8'h00);
        mem_op({6'b100100, 1'b1, 5'd20, 4'hc}, 1, 16'h0101, 1'b1, 8'h3c);
        mem_op({2'b10, 1'b0, 1'b0, 2'b10, 1'b0, 5'd21, 4'h8}, 1, 16'h0100, 1'b0, 8'h00);
        mem_op({7'b1000001, 5'd21, 4'h8}, 1, 16'h00f0, 1'b1, 8'h3c);
        exec({6'b001011, 1'b1, 5'd22, 4'h0}, 16'h0, 1'b0, 8'h00, 1, 1);
        mem_op({6'b100100, 1'b1, 5'd22, 4'hc}, 1, 16'h0101, 1'b1, 8'ha5);
        mem_op({6'b100100, 1'b0, 5'd23, 4'h1}, 1, 16'h0101, 1'b0, 8'h00);
        mem_op({2'b10, 1'b0, 1'b0, 2'b00, 1'b0, 5'd24, 4'h0}, 1, 16'h0102, 1'b0, 8'h00);
        axi_rd(`CBLS_OFS_PC);
        chk(rd, {22'h0, exp_pc});
        wrap_up();
    end
endmodule
